// >>> logic/ftm_modulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_regs.svh"
module ftm_modulator
  import ftm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic [2:0] i_mod_scheme,
  input wire logic [8:0] i_deviation_word,
  input wire logic i_output_halving_bit,
  input wire logic [3:0] i_demodulator_divider,
  input wire logic [7:0] i_recovery_clock_divider,
  input wire logic i_clk_cfg_write,
  input wire logic [1:0] i_clk_invert,
  input wire logic i_tx_serial_data_pin,
  input wire logic i_amp_on_bit,
  input wire logic i_tx_select,
  input wire logic [5:0] i_amp_power_code,
  input wire logic [2:0] i_ramp_rate,
  input wire logic [1:0] i_amp_bias_field,
  output logic o_tx_bit_clock_pin,
  output logic signed [2:0] o_symbol_level,
  output logic o_symbol_strobe,
  output logic signed [12:0] o_freq_offset,
  output logic [5:0] o_amp_code,
  output logic o_amp_stage_on,
  output logic [1:0] o_amp_bias
);
  // ==========================================================
  // Whole module state in one record.
  typedef struct packed {
    logic data_s1;
    logic data_s2;
    logic started;
    logic [11:0] div_cnt;
    logic [4:0] sub_cnt;
    logic clk_int;
    logic pin;
    logic pre_d1;
    logic pre_d2;
    logic pair_phase;
    logic msb_hold;
    logic signed [2:0] level;
    logic strobe;
    logic last_bit;
    logic signed [12:0] offset;
    logic [1:0] bias;
  } ftm_mod_state_t;

  ftm_mod_state_t st_r, st_nxt;
  ftm_mod_t mode;
  logic [3:0] demod_eff;
  logic [7:0] recov_eff;
  logic [11:0] div_prod;
  logic [11:0] div_last;
  logic sub_tick;
  logic inverted;
  logic oversampled;
  logic three_level;
  logic four_level;
  logic sample;
  logic bit_in;
  logic pre_now;
  logic signed [2:0] lvl_calc;
  logic signed [12:0] lvl_ext;
  logic signed [12:0] word_ext;
  logic signed [12:0] prod;

  // ==========================================================
  // Mode decode.
  // Filtered variants share the unfiltered symbol mapping; shaping
  // happens downstream of this block.
  always_comb
  begin
    mode = ftm_mod_t'(i_mod_scheme);
    oversampled = (mode == FTM_MOD_OVS);
    three_level = (mode == FTM_MOD_3FSK) || (mode == FTM_MOD_RC3); // RULE_16
    four_level = (mode == FTM_MOD_4FSK) || (mode == FTM_MOD_RC4);
    inverted = (i_clk_invert != 2'b00);
  end

  // ==========================================================
  // Reference divider: one sub-tick per demodulator times
  // recovery divide, 32 sub-ticks per bit.
  // Each zero divider field is treated as divide by one on its own, so
  // the clock never stalls and the other field still sets the rate.
  always_comb
  begin
    demod_eff = (i_demodulator_divider == 4'h0) ? 4'h1 : i_demodulator_divider;
    recov_eff = (i_recovery_clock_divider == 8'h00) ? 8'h01 : i_recovery_clock_divider;
    div_prod = {8'h00, demod_eff} * {4'h0, recov_eff}; // RULE_08
    div_last = div_prod - 12'h001;
    sub_tick = (st_r.div_cnt >= div_last);
  end

  // ==========================================================
  // Bit timing, sampling and symbol mapping.
  always_comb
  begin
    st_nxt = st_r;
    sample = 1'b0;
    bit_in = st_r.data_s2;
    pre_now = 1'b0;
    lvl_calc = st_r.level;
    st_nxt.strobe = 1'b0;
    st_nxt.bias = i_amp_bias_field;

    // Two-stage synchroniser on the asynchronous data pin.
    st_nxt.data_s1 = i_tx_serial_data_pin;
    st_nxt.data_s2 = st_r.data_s1;

    // Divider and sub-tick counters run freely.
    st_nxt.div_cnt = sub_tick ? 12'h000 : st_r.div_cnt + 12'h001;
    if (sub_tick)
    begin
      st_nxt.sub_cnt = st_r.sub_cnt + 5'h01; // RULE_07
    end
    st_nxt.clk_int = (st_nxt.sub_cnt < `FTM_SUB_HALF);

    // Sample point: rising edge, or half a bit later when inverted.
    if (oversampled)
    begin
      sample = sub_tick; // RULE_20
    end
    else if (st_r.started && sub_tick)
    begin
      sample = inverted ? (st_nxt.sub_cnt == `FTM_SUB_HALF) // RULE_19
                        : (st_nxt.sub_cnt == 5'h00);
    end

    // Divider write restarts the clock so its first pin rise follows
    // one sub-tick later and carries the first MSB; when inverted the
    // phase starts half a bit on, so no early pulse reaches the host.
    if (i_clk_cfg_write)
    begin
      st_nxt.started = 1'b1; // RULE_18
      st_nxt.div_cnt = 12'h000;
      st_nxt.sub_cnt = inverted ? 5'(`FTM_SUB_HALF - 5'h01) : `FTM_SUB_LAST;
      st_nxt.clk_int = inverted;
      st_nxt.pre_d1 = 1'b0;
      st_nxt.pre_d2 = 1'b0;
      st_nxt.pair_phase = 1'b0;
      sample = 1'b0;
    end

    if (sample)
    begin
      st_nxt.last_bit = bit_in;
      if (three_level)
      begin
        // Precoder inverts the 1 - D^2 shaping; encoder applies it.
        pre_now = bit_in ^ st_r.pre_d2; // RULE_14
        st_nxt.pre_d2 = st_r.pre_d1;
        st_nxt.pre_d1 = pre_now;
        case ({pre_now, st_r.pre_d2})
          2'b10: lvl_calc = `FTM_LVL_P1;
          2'b01: lvl_calc = `FTM_LVL_M1;
          default: lvl_calc = `FTM_LVL_ZERO; // RULE_13
        endcase
        st_nxt.strobe = 1'b1; // RULE_15
      end
      else if (four_level)
      begin
        // First bit of a pair is the MSB; the symbol goes out on the
        // second bit, so the symbol rate is half the bit rate.
        if (!st_r.pair_phase)
        begin
          st_nxt.msb_hold = bit_in;
          st_nxt.pair_phase = 1'b1;
        end
        else
        begin
          case ({st_r.msb_hold, bit_in}) // RULE_17
            2'b00: lvl_calc = `FTM_LVL_M3;
            2'b01: lvl_calc = `FTM_LVL_M1;
            2'b11: lvl_calc = `FTM_LVL_P1;
            default: lvl_calc = `FTM_LVL_P3; // RULE_10
          endcase
          st_nxt.pair_phase = 1'b0;
          st_nxt.strobe = 1'b1;
        end
      end
      else
      begin
        // Binary modes shift the divider up or down per bit.
        lvl_calc = bit_in ? `FTM_LVL_P1 : `FTM_LVL_M1; // RULE_11
        st_nxt.strobe = 1'b1;
      end
    end
    st_nxt.level = lvl_calc;

    // Clock pin is silent before start and in oversampled mode.
    st_nxt.pin = st_nxt.started && !oversampled && (st_nxt.clk_int ^ inverted);

    // Deviation offset in units of compare frequency over 2^17, so
    // the halved case stays exact without a fractional bit.
    lvl_ext = 13'(st_nxt.level);
    word_ext = $signed({4'h0, i_deviation_word});
    prod = lvl_ext * word_ext; // RULE_09
    st_nxt.offset = i_output_halving_bit ? prod : 13'(prod <<< 1);
  end

  // ==========================================================
  // State register.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Output power stage sequencing.
  ftm_pa_ramp u_pa_ramp
  (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_sub_tick(sub_tick),
    .i_ramp_rate(i_ramp_rate),
    .i_target(i_amp_power_code),
    .i_amp_on_bit(i_amp_on_bit),
    .i_tx_select(i_tx_select),
    .o_code(o_amp_code),
    .o_stage_on(o_amp_stage_on)
  );

  assign o_tx_bit_clock_pin = st_r.pin;
  assign o_symbol_level = st_r.level;
  assign o_symbol_strobe = st_r.strobe;
  assign o_freq_offset = st_r.offset;
  assign o_amp_bias = st_r.bias;

  // ==========================================================
  // Checks on clocking and symbol mapping.
  a_clock_gated: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_18
    !st_r.started |-> !o_tx_bit_clock_pin)
    else $error("bit clock ran before divider write");
  a_start_cause: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_18
    $rose(st_r.started) |-> $past(i_clk_cfg_write))
    else $error("clock started without a write");
  a_ovs_noclk: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_20
    oversampled && $past(oversampled) |-> !o_tx_bit_clock_pin)
    else $error("clock output in oversampled mode");
  a_three_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_13
    o_symbol_strobe && $past(three_level) && !st_r.last_bit
      |-> o_symbol_level == 3'sh0)
    else $error("three-level zero not on carrier");
  a_four_outer: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_10
    o_symbol_strobe && $past(four_level)
      |-> (o_symbol_level != 3'sh0) && (o_symbol_level != 3'sh2)
          && (o_symbol_level != -3'sh2))
    else $error("four-level symbol off grid");
  a_offset_calc: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_09
    $past(i_output_halving_bit) && $stable(o_symbol_level)
      && $stable(i_deviation_word) && $stable(i_output_halving_bit)
      |=> o_freq_offset == (13'(o_symbol_level) * $signed({4'h0, i_deviation_word})))
    else $error("halved deviation offset wrong");
  a_bit_period: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_07
    sub_tick && !i_clk_cfg_write |=> st_r.div_cnt == 12'h000)
    else $error("sub-tick divider did not wrap");
endmodule : ftm_modulator
`default_nettype wire

// >>> logic/ftm_pa_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "ftm_regs.svh"
module ftm_pa_ramp
  import ftm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_sub_tick,
  input wire logic [2:0] i_ramp_rate,
  input wire logic [5:0] i_target,
  input wire logic i_amp_on_bit,
  input wire logic i_tx_select,
  output logic [5:0] o_code,
  output logic o_stage_on
);
  typedef struct packed {
    ftm_ramp_st_t st;
    logic [5:0] code;
    logic stage_on;
    logic [4:0] tick_cnt;
  } ftm_ramp_state_t;
  ftm_ramp_state_t st_r, st_nxt;
  logic [4:0] interval_last;
  logic [5:0] step;
  logic step_tick;
  logic [6:0] up_sum;

  // ==========================================================
  // Rates 0..5 give 1..32 codes per bit; 6 and 7 take bigger steps.
  always_comb
  begin
    interval_last = 5'(`FTM_SUB_LAST >> i_ramp_rate); // RULE_02
    step = 6'h01;
    if (i_ramp_rate > `FTM_SUB_BITS_LOG2)
    begin
      interval_last = 5'h00;
      step = 6'(6'h01 << (i_ramp_rate - `FTM_SUB_BITS_LOG2));
    end
    step_tick = i_sub_tick && (st_r.tick_cnt >= interval_last);
    up_sum = {1'b0, st_r.code} + {1'b0, step};
  end

  // ==========================================================
  // Ramp sequencer; the amp-on bit bypasses the down ramp.
  always_comb
  begin
    st_nxt = st_r;
    if (i_sub_tick)
    begin
      st_nxt.tick_cnt = step_tick ? 5'h00 : st_r.tick_cnt + 5'h01;
    end
    case (st_r.st)
      FTM_RAMP_OFF:
      begin
        st_nxt.code = `FTM_CODE_ZERO;
        st_nxt.stage_on = 1'b0;
        if (i_amp_on_bit && i_tx_select)
        begin
          st_nxt.st = FTM_RAMP_UP;
          st_nxt.stage_on = 1'b1;
          st_nxt.tick_cnt = 5'h00;
        end
      end
      FTM_RAMP_UP:
      begin
        if (step_tick) // RULE_21
        begin
          st_nxt.code = (up_sum >= {1'b0, i_target}) ? i_target : up_sum[5:0];
        end
        if (st_r.code >= i_target)
        begin
          st_nxt.code = i_target;
          st_nxt.st = FTM_RAMP_HOLD;
        end
        if (!i_tx_select)
        begin
          st_nxt.st = FTM_RAMP_DOWN; // RULE_04
        end
      end
      FTM_RAMP_HOLD:
      begin
        st_nxt.code = i_target; // RULE_01
        if (!i_tx_select)
        begin
          st_nxt.st = FTM_RAMP_DOWN;
        end
      end
      FTM_RAMP_DOWN:
      begin
        if (step_tick)
        begin
          st_nxt.code = (st_r.code > step) ? st_r.code - step : `FTM_CODE_ZERO;
        end
        if (st_r.code == `FTM_CODE_ZERO)
        begin
          st_nxt.st = FTM_RAMP_OFF;
          st_nxt.stage_on = 1'b0;
        end
        else if (i_tx_select && i_amp_on_bit)
        begin
          st_nxt.st = FTM_RAMP_UP;
        end
      end
      default:
      begin
        st_nxt.st = FTM_RAMP_OFF;
      end
    endcase
    // A cleared amp-on bit cuts the stage at once, overriding any ramp.
    if (!i_amp_on_bit)
    begin
      st_nxt.st = FTM_RAMP_OFF; // RULE_03
      st_nxt.code = `FTM_CODE_ZERO;
      st_nxt.stage_on = 1'b0; // RULE_06
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_r <= '{FTM_RAMP_OFF, 6'h00, 1'b0, 5'h00};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_code = st_r.code;
  assign o_stage_on = st_r.stage_on;

  // ==========================================================
  // Checks on the power ramp.
  a_hard_off: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_03
    !i_amp_on_bit |=> (o_code == 6'h00) && !o_stage_on)
    else $error("amplifier did not turn off hard");
  a_step_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_02
    (st_r.st == FTM_RAMP_UP) && $past(st_r.st == FTM_RAMP_UP)
      |-> (o_code - $past(o_code)) <= `FTM_STEP_MAX)
    else $error("ramp step too large");
  a_soft_down: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RULE_04
    (st_r.st == FTM_RAMP_HOLD) && !i_tx_select && i_amp_on_bit && (o_code > 6'h04)
      |=> o_stage_on && (o_code == $past(o_code)))
    else $error("transmit select did not ramp down");
endmodule : ftm_pa_ramp
`default_nettype wire

// >>> logic/ftm_pkg.sv
// ==========================================================
// Shared types of the transmit modulator.
package ftm_pkg;
  typedef enum logic [2:0]
  {
    FTM_MOD_2FSK = 3'b000,
    FTM_MOD_GFSK = 3'b001,
    FTM_MOD_3FSK = 3'b010,
    FTM_MOD_4FSK = 3'b011,
    FTM_MOD_OVS = 3'b100,
    FTM_MOD_RC2 = 3'b101,
    FTM_MOD_RC3 = 3'b110,
    FTM_MOD_RC4 = 3'b111
  } ftm_mod_t;
  typedef enum logic [1:0]
  {
    FTM_RAMP_OFF = 2'b00,
    FTM_RAMP_UP = 2'b01,
    FTM_RAMP_HOLD = 2'b10,
    FTM_RAMP_DOWN = 2'b11
  } ftm_ramp_st_t;
endpackage : ftm_pkg

// >>> logic/ftm_regs.svh
// Function
// RULE_01: Six-bit power code sets amplifier output level.
// RULE_02: Ramp walks power codes at eight selectable rates.
// RULE_03: Amp-on bit ramps up, drops off immediately.
// RULE_04: Transmit select ramps both up and down.
// RULE_05: Software keeps bias default, raises above 10 dBm.
// RULE_06: Clearing amp-on powers down the output stage.
// RULE_07: Bit clock is reference over dividers times 32.
// RULE_08: Four-bit demodulator and eight-bit recovery dividers.
// RULE_09: Deviation is word times compare frequency, halvable.
// RULE_10: Four-level symbols at one and three deviations.
// RULE_11: Mode 000 sends binary FSK per data bit.
// RULE_12: Software sets quarter-rate deviation for MSK.
// RULE_13: Three-level zero is carrier, one is offset.
// RULE_14: Precoder XOR two back, encoder subtracts two back.
// RULE_15: Three-level encoder emits one symbol per bit.
// RULE_16: Mode 010 selects three-level FSK.
// RULE_17: Four-level gray maps bit pairs to symbols.
// RULE_18: Clock starts after divider write; MSB first.
// RULE_19: Data sampled on rising edge; invert adds half.
// RULE_20: Oversampled mode: no clock, 32x data sampling.
// RULE_21: Ramp steps one interval at a time, holds target.
`ifndef FTM_REGS_SVH
`define FTM_REGS_SVH
// ==========================================================
// Timing and field constants.
`define FTM_CLK_PERIOD_NS 5
`define FTM_SUB_LAST 5'h1F
`define FTM_SUB_HALF 5'h10
`define FTM_SUB_BITS_LOG2 3'h5
`define FTM_CODE_ZERO 6'h00
`define FTM_LVL_P3 3'sh3
`define FTM_LVL_P1 3'sh1
`define FTM_LVL_ZERO 3'sh0
`define FTM_LVL_M1 -3'sh1
`define FTM_LVL_M3 -3'sh3
`define FTM_STEP_MAX 6'h04
`endif

// >>> verification/ftm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Host that feeds serial transmit bits.
module ftm_host_model
(
  input wire logic i_core_clk,
  input wire logic i_bit_clk,
  input wire logic i_inverted,
  output var logic o_data
);
  logic bits_q[$];
  logic last_r = 1'b0;
  logic prev_r = 1'b0;

  // Queue a bit; the head bit is on the line before the first clock pulse.
  task push_bit(input logic b);
    bits_q.push_back(b);
  endtask : push_bit

  // Move on just after the pin edge to the active level, the falling edge when inverted, so a change never races the sample.
  // With nothing queued the line shows the inverse of the last bit, not a stale copy.
  always @(posedge i_core_clk)
  begin
    #1;
    if (i_bit_clk !== prev_r && i_bit_clk === !i_inverted && bits_q.size() > 0)
    begin
      last_r = bits_q.pop_front();
    end
    prev_r = i_bit_clk;
    o_data = (bits_q.size() > 0) ? bits_q[0] : !last_r;
  end

  initial o_data = 1'b0;
endmodule : ftm_host_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench for the transmit modulator.
module tb_top;
  import ftm_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [2:0] i_mod_scheme = 3'h0;
  logic [8:0] i_deviation_word = 9'h001;
  logic i_output_halving_bit = 1'b0;
  logic [3:0] i_demodulator_divider = 4'h1;
  logic [7:0] i_recovery_clock_divider = 8'h01;
  logic i_clk_cfg_write = 1'b0;
  logic [1:0] i_clk_invert = 2'h0;
  logic i_amp_on_bit = 1'b0;
  logic i_tx_select = 1'b0;
  logic [5:0] i_amp_power_code = 6'h00;
  logic [2:0] i_ramp_rate = 3'h0;
  logic [1:0] i_amp_bias_field = 2'h0;
  logic data_w;
  logic clk_pin;
  logic signed [2:0] lvl;
  logic stb;
  logic signed [12:0] off;
  logic [5:0] code;
  logic stage;
  logic [1:0] bias;
  int n_errors = 0;
  int samples_checked = 0;
  integer seed = 32'h9956_06f9;
  bit mon_en = 1'b0;
  int exp_lvl_q[$];
  int exp_off_q[$];
  int dd[3] = '{2, 0, 1};
  int rr[3] = '{3, 1, 150};

  always #2.5 i_core_clk = ~i_core_clk;

  ftm_modulator dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_mod_scheme(i_mod_scheme),
    .i_deviation_word(i_deviation_word), .i_output_halving_bit(i_output_halving_bit),
    .i_demodulator_divider(i_demodulator_divider),
    .i_recovery_clock_divider(i_recovery_clock_divider), .i_clk_cfg_write(i_clk_cfg_write),
    .i_clk_invert(i_clk_invert), .i_tx_serial_data_pin(data_w), .i_amp_on_bit(i_amp_on_bit),
    .i_tx_select(i_tx_select), .i_amp_power_code(i_amp_power_code), .i_ramp_rate(i_ramp_rate),
    .i_amp_bias_field(i_amp_bias_field), .o_tx_bit_clock_pin(clk_pin), .o_symbol_level(lvl),
    .o_symbol_strobe(stb), .o_freq_offset(off), .o_amp_code(code), .o_amp_stage_on(stage),
    .o_amp_bias(bias));

  ftm_host_model host (.i_core_clk(i_core_clk), .i_bit_clk(clk_pin),
    .i_inverted(|i_clk_invert), .o_data(data_w));

  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cyc

  task chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task finish_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task timeout;
    n_errors++;
    $display("BAD wait_limit expected 1 seen 0");
    finish_test();
  endtask : timeout

  task do_reset;
    i_rstn = 1'b0;
    cyc(20);
    i_rstn = 1'b1;
  endtask : do_reset

  task start_clk;
    i_clk_cfg_write = 1'b1;
    cyc(1);
    i_clk_cfg_write = 1'b0;
  endtask : start_clk

  task wait_code(input logic [5:0] v, output int n);
    for (n = 0; n < 2000 && code !== v; n++) cyc(1);
    if (n == 2000) timeout();
  endtask : wait_code

  // Queue bits at the host and note the symbol each bit, or bit pair, must give.
  task stream(input ftm_mod_t m, input logic [1:0] inv, input logic [15:0] bits, input int n);
    int i;
    int k;
    int p;
    int p1;
    int p2;
    int lv;
    logic b;
    logic hb;
    do_reset();
    i_mod_scheme = m;
    i_clk_invert = inv;
    i_deviation_word = 9'({$random(seed)} % 511 + 1);
    i_output_halving_bit = 1'($random(seed));
    p1 = 0;
    p2 = 0;
    hb = 1'b0;
    for (i = 0; i < n; i++)
    begin
      b = bits[n - 1 - i];
      host.push_bit(b);
      lv = 99;
      case (m)
        FTM_MOD_3FSK, FTM_MOD_RC3:
        begin
          p = int'(b) ^ p2;
          lv = p - p2;
          p2 = p1;
          p1 = p;
        end
        FTM_MOD_4FSK, FTM_MOD_RC4:
          if (i % 2 == 1) lv = b ? (hb ? 1 : -1) : (hb ? 3 : -3);
          else hb = b;
        default: lv = b ? 1 : -1;
      endcase
      if (lv != 99)
      begin
        exp_lvl_q.push_back(lv);
        exp_off_q.push_back(lv * int'(i_deviation_word) * (i_output_halving_bit ? 1 : 2));
      end
    end
    mon_en = 1'b1;
    cyc(20);
    chk("clk_before_start", 13'h0000, 13'(clk_pin));
    start_clk();
    for (k = 0; k < 40 * n + 100 && exp_lvl_q.size() > 0; k++) cyc(1);
    if (exp_lvl_q.size() > 0) timeout();
    mon_en = 1'b0;
  endtask : stream

  // Each strobe takes the oldest note; a strobe with no note pending is itself a fault.
  always @(negedge i_core_clk)
  begin
    if (mon_en && stb === 1'b1)
    begin
      if (exp_lvl_q.size() == 0)
        chk("extra_symbol", 13'h0000, 13'h0001);
      else
      begin
        chk("level", 13'(exp_lvl_q.pop_front()), 13'(lvl));
        chk("offset", 13'(exp_off_q.pop_front()), off);
      end
    end
  end

  // Main sequence: data modes, clock timing, oversampling, then amplifier ramps.
  initial
  begin
    int mi;
    int k;
    int h;
    int l;
    int s;
    int e;
    do_reset();
    for (mi = 0; mi < 8; mi++)
      if (mi != 4) stream(ftm_mod_t'(mi), 2'h0, 16'($random(seed)), 16);
    stream(FTM_MOD_3FSK, 2'h0, 16'h02c9, 10);
    stream(FTM_MOD_4FSK, 2'h0, 16'h001e, 8);
    stream(FTM_MOD_2FSK, 2'h1, 16'($random(seed)), 16);
    stream(FTM_MOD_4FSK, 2'h2, 16'($random(seed)), 16);
    for (mi = 0; mi < 3; mi++)
    begin
      do_reset();
      i_demodulator_divider = 4'(dd[mi]);
      i_recovery_clock_divider = 8'(rr[mi]);
      start_clk();
      for (k = 0; k < 5000 && clk_pin !== 1'b1; k++) cyc(1);
      for (h = 0; h < 5000 && clk_pin === 1'b1; h++) cyc(1);
      for (l = 0; l < 5000 && clk_pin !== 1'b1; l++) cyc(1);
      if (l == 5000) timeout();
      e = (dd[mi] == 0 ? 1 : dd[mi]) * rr[mi] * 32;
      chk("clk_high", 13'(e / 2), 13'(h));
      chk("clk_period", 13'(e), 13'(h + l));
    end
    do_reset();
    i_demodulator_divider = 4'h1;
    i_recovery_clock_divider = 8'h01;
    i_mod_scheme = FTM_MOD_OVS;
    start_clk();
    h = 0;
    l = 0;
    for (k = 0; k < 320; k++)
    begin
      cyc(1);
      h += (clk_pin === 1'b1);
      l += (stb === 1'b1);
    end
    chk("ovs_clock", 13'h0000, 13'(h));
    chk("ovs_samples", 13'h0001, 13'(l >= 40));
    do_reset();
    i_mod_scheme = FTM_MOD_2FSK;
    i_amp_bias_field = 2'($random(seed));
    start_clk();
    cyc(2);
    chk("amp_bias", 13'(i_amp_bias_field), 13'(bias));
    i_amp_bias_field = 2'h0;
    for (mi = 0; mi < 8; mi++)
    begin
      i_ramp_rate = 3'(mi);
      i_amp_power_code = 6'h10;
      i_amp_on_bit = 1'b1;
      i_tx_select = 1'b1;
      s = (mi <= 5) ? (32 >> mi) : 1;
      e = (mi <= 5) ? 16 * s : (16 >> (mi - 5));
      wait_code(6'h10, k);
      chk("ramp_up_time", 13'h0001, 13'(k >= e - s - 2 && k <= e + s + 2));
      cyc(40);
      chk("hold_code", 13'h0010, 13'(code));
      chk("stage_on", 13'h0001, 13'(stage));
      i_tx_select = 1'b0;
      wait_code(6'h00, k);
      chk("ramp_down_time", 13'h0001, 13'(k >= e - s - 2 && k <= e + s + 2));
      cyc(3);
      chk("stage_after_down", 13'h0000, 13'(stage));
    end
    i_tx_select = 1'b1;
    wait_code(6'h10, k);
    i_amp_on_bit = 1'b0;
    cyc(2);
    chk("hard_off_code", 13'h0000, 13'(code));
    chk("hard_off_stage", 13'h0000, 13'(stage));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
